// ### verilog/gcs_pkg.sv
// How it works
// - each network is driven only by its own control block, one to one
// - eight blocks on small parts, sixteen on large parts, sixteen max
// - four blocks per side share four pins and two counters; each has its own logic signal
// - each block takes two pins, two counters, one dual pin, one logic
// - fabric two-bit select picks pin a, pin b, counter 0 or 1
// - dual pin or logic path is static config, frozen in user mode
// - loop reference mux set by config or by manual switchover
// - only loop counters 0 and 1 reach a block, third never
// - unused networks are statically powered down by config
// - fabric enable gates the network; disabled means no clock
// - gating is at network level; loop reference never affected
// - network enable is sampled at the falling edge of input clock
// - dedicated pins may carry clocks or global control signals
// - internal logic can drive a network as a low-skew path
// - left/right offer two dual pins, top/bottom four, plus corners
// - only one pin of each corner pair feeds the block
package gcs_pkg;
    localparam int SIDES = 4;
    localparam int BLOCKS_PER_SIDE = 4;
    localparam int MAX_BLOCKS = 16;
    localparam int SMALL_BLOCKS = 8;
    localparam int PINS_PER_SIDE = 4;
    localparam int COUNTERS_ROUTED = 2;
    localparam int DP_LR = 2;
    localparam int DP_TB = 4;
    localparam int CORNERS = 2;
    localparam int BLOCK_INPUTS = 6;
    localparam int SRC_DP_IDX = 4;
    localparam int SRC_LOGIC_IDX = 5;

    localparam logic [7:0] OFS_GLOBAL_CFG = 8'h00;
    localparam logic [7:0] OFS_LOOP_CFG = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [1:0] OFS_BLOCK_PAGE = 2'h1;

    localparam int GCFG_USER_BIT = 0;
    localparam int LCFG_STRIDE = 4;
    localparam int LCFG_REF_SEL = 0;
    localparam int LCFG_MANUAL = 1;
    localparam int LCFG_CORNER_PICK = 2;
    localparam int LCFG_CORNER_USE = 3;
    localparam int BCFG_SEL_LSB = 0;
    localparam int BCFG_EN_BIT = 2;
    localparam int BCFG_OUT_BIT = 3;
    localparam int BCFG_PATH_LSB = 4;
    localparam int BCFG_USED_BIT = 6;
    localparam int STAT_USER_BIT = 16;
    localparam int STAT_LARGE_BIT = 17;

    localparam logic [15:0] LCFG_RST = 16'h0000;
    localparam logic [1:0] PATH_RST = 2'h0;
    localparam logic USED_RST = 1'b1;

    typedef enum logic [1:0] {
        GCS_PATH_DYNAMIC = 2'b00,
        GCS_PATH_DUAL_PIN = 2'b01,
        GCS_PATH_LOGIC = 2'b10
    } gcs_path_t;

    typedef enum logic {
        GCS_BUS_IDLE = 1'b0,
        GCS_BUS_ANSWER = 1'b1
    } gcs_bus_state_t;
endpackage

// ### verilog/gcs_ctrl_block.sv
`timescale 1ns/100ps
`default_nettype none
module gcs_ctrl_block (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // sources: pin a, pin b, counter 0, counter 1, dual pin, logic
    input wire logic [5:0] src_in,
    input wire logic [1:0] dyn_sel_in,
    input wire logic [1:0] path_in,
    input wire logic used_in,
    input wire logic enable_in,
    // network side
    output logic net_out,
    output logic en_state_out,
    output logic level_out
);
    logic sel_level;
    logic clkin_r;
    logic en_r;
    logic net_r;
    logic fall;

    always_comb
    begin
        case (path_in)
            gcs_pkg::GCS_PATH_DUAL_PIN: sel_level = src_in[gcs_pkg::SRC_DP_IDX];
            gcs_pkg::GCS_PATH_LOGIC:
                sel_level = src_in[gcs_pkg::SRC_LOGIC_IDX];
            default: sel_level = src_in[dyn_sel_in];
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            clkin_r <= 1'b0;
        else
            clkin_r <= sel_level;
    end

    assign fall = clkin_r & ~sel_level;

    // enable moves only while the clock is low, so no pulse is cut short
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            en_r <= 1'b0;
        else if (fall)
            en_r <= enable_in & used_in;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            net_r <= 1'b0;
        else
            net_r <= used_in & en_r & sel_level;
    end

    assign net_out = net_r;
    assign en_state_out = en_r;
    assign level_out = clkin_r;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence clk_fall_s;
        clkin_r && !sel_level;
    endsequence

    en_sample_a: assert property (clk_fall_s |=> en_r == $past(enable_in && used_in)) else $error("enable not taken at falling edge");
    en_hold_a: assert property (!(clkin_r && !sel_level) |=> $stable(en_r)) else $error("enable moved outside falling edge");
    gated_low_a: assert property (!en_r |=> !net_r) else $error("disabled network toggled");
    follow_src_a: assert property (en_r && used_in |=> net_r == $past(sel_level)) else $error("network does not follow source");
    power_down_a: assert property (!used_in |=> !net_r) else $error("unused network not powered down");
endmodule
`default_nettype wire

// ### verilog/gcs_clock_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module gcs_clock_ctrl #(
    parameter bit LARGE_DEVICE = 1'b1
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // avalon-mm slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // per-side source pools, side 0 left, 1 right, 2 top, 3 bottom
    input wire logic [15:0] clk_pin_in,
    input wire logic [7:0] loop_counter_in,
    input wire logic [3:0] dual_pin_lr_in,
    input wire logic [7:0] dual_pin_tb_in,
    input wire logic [7:0] corner_dual_purpose_clock_pin_in,
    input wire logic [15:0] logic_element_in,
    // fabric controls
    input wire logic [31:0] dynamic_source_select_in,
    input wire logic [15:0] net_enable_in,
    input wire logic [3:0] loop_reference_switch_in,
    // outputs
    output logic [15:0] global_clock_out,
    output logic [3:0] loop_ref_out
);
    gcs_pkg::gcs_bus_state_t state_r;
    gcs_pkg::gcs_bus_state_t state_nxt;
    logic req;
    logic wr_acc;
    logic user_mode_r;
    logic [15:0] loop_cfg_r;
    logic [31:0] path_r;
    logic [15:0] used_r;
    logic [15:0] en_state;
    logic [15:0] net;
    logic [3:0] corner_pick;
    logic [31:0] readdata_r;
    logic [31:0] rd_word;
    logic blk_hit;
    logic [3:0] blk_idx;
    logic [31:0] wmerged;

    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
            if (be[b])
                r[b*8 +: 8] = new_v[b*8 +: 8];
        return r;
    endfunction

    // bus: every access waits one cycle, then answers
    assign req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = req && (state_r != gcs_pkg::GCS_BUS_ANSWER);
    assign wr_acc = avs_write_in && (state_r == gcs_pkg::GCS_BUS_ANSWER);
    assign blk_hit = avs_address_in[7:6] == gcs_pkg::OFS_BLOCK_PAGE;
    assign blk_idx = avs_address_in[5:2];

    always_comb
    begin
        case (state_r)
            gcs_pkg::GCS_BUS_IDLE:
                state_nxt = req ? gcs_pkg::GCS_BUS_ANSWER
                                : gcs_pkg::GCS_BUS_IDLE;
            gcs_pkg::GCS_BUS_ANSWER: state_nxt = gcs_pkg::GCS_BUS_IDLE;
            default: state_nxt = gcs_pkg::GCS_BUS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            state_r <= gcs_pkg::GCS_BUS_IDLE;
        else
            state_r <= state_nxt;
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (blk_hit)
        begin
            rd_word[gcs_pkg::BCFG_SEL_LSB +: 2] =
                dynamic_source_select_in[blk_idx*2 +: 2];
            rd_word[gcs_pkg::BCFG_EN_BIT] = en_state[blk_idx];
            rd_word[gcs_pkg::BCFG_OUT_BIT] = net[blk_idx];
            rd_word[gcs_pkg::BCFG_PATH_LSB +: 2] = path_r[blk_idx*2 +: 2];
            rd_word[gcs_pkg::BCFG_USED_BIT] = used_r[blk_idx];
        end
        else if (avs_address_in == gcs_pkg::OFS_GLOBAL_CFG)
            rd_word[gcs_pkg::GCFG_USER_BIT] = user_mode_r;
        else if (avs_address_in == gcs_pkg::OFS_LOOP_CFG)
            rd_word[15:0] = loop_cfg_r;
        else if (avs_address_in == gcs_pkg::OFS_STATUS)
        begin
            rd_word[15:0] = en_state;
            rd_word[gcs_pkg::STAT_USER_BIT] = user_mode_r;
            rd_word[gcs_pkg::STAT_LARGE_BIT] = LARGE_DEVICE;
        end
    end

    assign wmerged = be_merge(rd_word, avs_writedata_in, avs_byteenable_in);

    // unmapped addresses read zero and ignore writes
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            readdata_r <= 32'h0000_0000;
        else if (avs_read_in && state_r == gcs_pkg::GCS_BUS_IDLE)
            readdata_r <= rd_word;
    end

    assign avs_readdata_out = readdata_r;

    // user mode is entered once and left only by reset
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            user_mode_r <= 1'b0;
        else if (wr_acc && avs_address_in == gcs_pkg::OFS_GLOBAL_CFG
                 && wmerged[gcs_pkg::GCFG_USER_BIT])
            user_mode_r <= 1'b1;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            loop_cfg_r <= gcs_pkg::LCFG_RST;
        else if (wr_acc && !user_mode_r
                 && avs_address_in == gcs_pkg::OFS_LOOP_CFG)
            loop_cfg_r <= wmerged[15:0];
    end

    // one block per network, each network driven by that block alone
    genvar gi;
    generate
        for (gi = 0; gi < gcs_pkg::MAX_BLOCKS; gi++)
        begin : g_blk
            localparam int S = gi / gcs_pkg::BLOCKS_PER_SIDE;
            localparam int K = gi % gcs_pkg::BLOCKS_PER_SIDE;
            localparam int KB = (K + 1) % gcs_pkg::PINS_PER_SIDE;
            localparam bit ACTIVE = LARGE_DEVICE || (gi < gcs_pkg::SMALL_BLOCKS);
            logic [5:0] src;
            logic dp;

            if (K == 0)
            begin : g_side
                logic ref_r;
                logic manual;
                logic pick;
                assign manual = loop_cfg_r[S*gcs_pkg::LCFG_STRIDE
                                           + gcs_pkg::LCFG_MANUAL];
                assign pick = manual ? loop_reference_switch_in[S]
                    : loop_cfg_r[S*gcs_pkg::LCFG_STRIDE
                                 + gcs_pkg::LCFG_REF_SEL];
                assign corner_pick[S] = loop_cfg_r[S*gcs_pkg::LCFG_STRIDE
                    + gcs_pkg::LCFG_CORNER_PICK]
                    ? corner_dual_purpose_clock_pin_in[S*2+1]
                    : corner_dual_purpose_clock_pin_in[S*2];
                // reference mux sits ahead of any gating on purpose
                always_ff @(posedge ref_clk_in or negedge rst_n_in)
                begin
                    if (!rst_n_in)
                        ref_r <= 1'b0;
                    else
                        ref_r <= pick ? clk_pin_in[S*4+1]
                                      : clk_pin_in[S*4];
                end
                assign loop_ref_out[S] = ref_r;

                loop_ref_a: assert property (@(posedge ref_clk_in)
                    disable iff (!rst_n_in)
                    manual |=> ref_r == $past(loop_reference_switch_in[S]
                        ? clk_pin_in[S*4+1] : clk_pin_in[S*4]))
                    else $error("loop reference ignores manual switch");
            end

            if (S < 2)
            begin : g_lr
                if (K < gcs_pkg::DP_LR)
                    assign dp = dual_pin_lr_in[S*gcs_pkg::DP_LR+K];
                else
                    assign dp = corner_pick[S];
            end
            else
            begin : g_tb
                if (K == gcs_pkg::DP_TB - 1)
                    assign dp = loop_cfg_r[S*gcs_pkg::LCFG_STRIDE
                        + gcs_pkg::LCFG_CORNER_USE] ? corner_pick[S]
                        : dual_pin_tb_in[(S-2)*gcs_pkg::DP_TB+K];
                else
                    assign dp = dual_pin_tb_in[(S-2)*gcs_pkg::DP_TB+K];
            end

            // third loop counter is never wired into a block
            assign src = {logic_element_in[gi], dp,
                          loop_counter_in[S*gcs_pkg::COUNTERS_ROUTED+1],
                          loop_counter_in[S*gcs_pkg::COUNTERS_ROUTED],
                          clk_pin_in[S*gcs_pkg::PINS_PER_SIDE+KB],
                          clk_pin_in[S*gcs_pkg::PINS_PER_SIDE+K]};

            always_ff @(posedge ref_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    path_r[gi*2 +: 2] <= gcs_pkg::PATH_RST;
                    used_r[gi] <= gcs_pkg::USED_RST;
                end
                else if (wr_acc && blk_hit && blk_idx == gi
                         && !user_mode_r)
                begin
                    path_r[gi*2 +: 2] <= wmerged[gcs_pkg::BCFG_PATH_LSB +: 2];
                    used_r[gi] <= wmerged[gcs_pkg::BCFG_USED_BIT];
                end
            end

            gcs_ctrl_block u_blk (
                .ref_clk_in(ref_clk_in),
                .rst_n_in(rst_n_in),
                .src_in(src),
                .dyn_sel_in(dynamic_source_select_in[gi*2 +: 2]),
                .path_in(path_r[gi*2 +: 2]),
                .used_in(used_r[gi] & ACTIVE),
                .enable_in(net_enable_in[gi]),
                .net_out(net[gi]),
                .en_state_out(en_state[gi]),
                .level_out()
            );
        end
    endgenerate

    assign global_clock_out = net;

    static_lock_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        user_mode_r |=> $stable(path_r) && $stable(used_r)
            && $stable(loop_cfg_r))
        else $error("static config changed in user mode");
    user_stick_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        user_mode_r |=> user_mode_r)
        else $error("user mode left without reset");
    small_off_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        (|global_clock_out[15:8]) |-> LARGE_DEVICE)
        else $error("absent network driven on small part");
    bus_answer_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in)
        req && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus answer later than one wait cycle");
endmodule
`default_nettype wire

// ### dv/gcs_fabric_model.sv
`timescale 1ns/100ps
`default_nettype none
module gcs_fabric_model (
    // clock, reset and run control
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    // source pools and fabric controls
    output logic [59:0] src_out,
    output logic [31:0] sel_out,
    output logic [15:0] en_out,
    output logic [3:0] sw_out
);
    logic [7:0] cnt_r;
    logic [2:0] ph_r [60];
    logic [1:0] dv_r [60];
    logic [1:0] st_r [16];
    logic [3:0] wt_r [16];
    // periods of 2, 4 or 8 cycles, so every source falls within 8 cycles
    always_comb
    begin
        for (int j = 0; j < 60; j++)
            src_out[j] = 1'((cnt_r + 8'(ph_r[j])) >> dv_r[j]);
    end
    // a source change waits 11 cycles with enable low, longer than any
    // source period, so the old latched enable has surely dropped
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_r <= 8'h00;
            sel_out <= 32'h0000_0000;
            en_out <= 16'h0000;
            sw_out <= 4'h0;
            for (int j = 0; j < 60; j++)
            begin
                ph_r[j] <= 3'($urandom);
                dv_r[j] <= 2'($urandom_range(2));
            end
            for (int i = 0; i < 16; i++)
                st_r[i] <= 2'h0;
        end
        else
        begin
            cnt_r <= cnt_r + 8'h01;
            if ($urandom_range(15) == 0)
                sw_out <= 4'($urandom);
            for (int i = 0; i < 16; i++)
            begin
                wt_r[i] <= wt_r[i] - 4'h1;
                if (st_r[i] == 2'h0 && !run_in)
                    en_out[i] <= 1'b0;
                else if (st_r[i] == 2'h0 && $urandom_range(31) == 0)
                begin
                    en_out[i] <= 1'b0;
                    wt_r[i] <= 4'hA;
                    st_r[i] <= 2'h1;
                end
                else if (st_r[i] == 2'h0 && $urandom_range(31) == 0)
                    en_out[i] <= ~en_out[i];
                else if (st_r[i] == 2'h1 && wt_r[i] == 4'h0)
                begin
                    sel_out[2*i+:2] <= 2'($urandom);
                    wt_r[i] <= 4'($urandom_range(4, 1));
                    st_r[i] <= 2'h2;
                end
                else if (st_r[i] == 2'h2 && wt_r[i] == 4'h0)
                begin
                    en_out[i] <= run_in;
                    st_r[i] <= 2'h0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic ref_clk_in = 1'b0;
    logic rst_n_in, run, avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [7:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out, sel, path_m, lcfg, q;
    logic [3:0] avs_byteenable_in, sw, loop_ref_out, lr;
    logic [59:0] src;
    logic [15:0] en, global_clock_out, prv, lat, eo, used_m;
    logic umode, s;
    int bad_count = 0;
    int tests_run = 0;
    int seed;
    always #50 ref_clk_in = ~ref_clk_in;
    gcs_fabric_model gcs_fabric_model_inst (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .run_in(run),
        .src_out(src),
        .sel_out(sel),
        .en_out(en),
        .sw_out(sw)
    );
    gcs_clock_ctrl #(.LARGE_DEVICE(1'b1)) gcs_clock_ctrl_inst (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .clk_pin_in(src[15:0]),
        .loop_counter_in(src[23:16]),
        .dual_pin_lr_in(src[27:24]),
        .dual_pin_tb_in(src[35:28]),
        .corner_dual_purpose_clock_pin_in(src[43:36]),
        .logic_element_in(src[59:44]),
        .dynamic_source_select_in(sel),
        .net_enable_in(en),
        .loop_reference_switch_in(sw),
        .global_clock_out(global_clock_out),
        .loop_ref_out(loop_ref_out)
    );
    function automatic logic src_of(input int i);
        logic [1:0] k;
        int sd;
        int kd;
        k = sel[2*i+:2];
        sd = i / 4;
        kd = i % 4;
        // dual pin path: side pins first, corner pick per side config
        if (path_m[2*i+:2] == gcs_pkg::GCS_PATH_DUAL_PIN)
        begin
            if (sd < 2 && kd < 2)
                return src[24+sd*2+kd];
            if (sd < 2 || (kd == 3 && lcfg[4*sd+3]))
                return src[36+sd*2+int'(lcfg[4*sd+2])];
            return src[28+(sd-2)*4+kd];
        end
        if (path_m[2*i+:2] == gcs_pkg::GCS_PATH_LOGIC)
            return src[44+i];
        if (k[1])
            return src[16+i/4*2+int'(k[0])];
        return src[i/4*4+(i%4+int'(k[0]))%4];
    endfunction
    function automatic logic [31:0] rd_exp(input logic [7:0] a);
        int i;
        i = int'(a[5:2]);
        if (a[7:6] == 2'h1)
            return {25'h0, used_m[i], path_m[2*i+:2], 4'h0};
        case (a)
            8'h00: return {31'h0, umode};
            8'h04: return lcfg;
            8'h08: return {14'h0, 1'b1, umode, lat};
            default: return 32'h0000_0000;
        endcase
    endfunction
    task automatic chk(input string m, input logic [31:0] g,
        input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // the mirrors move by non-blocking update so the reference model sees
    // a new setting from the edge after the write, as the design does
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_byteenable_in <= be;
        avs_write_in <= w;
        avs_read_in <= !w;
        do
        begin
            @(posedge ref_clk_in);
            n++;
        end
        while (avs_waitrequest_out !== 1'b0 && n < 40);
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        chk("bus answer", 32'(n), 32'h0000_0002);
        if (w && a == 8'h00 && d[0])
            umode <= 1'b1;
        for (int b = 0; b < 2; b++)
            if (w && a == 8'h04 && !umode && be[b])
                lcfg[8*b+:8] <= d[8*b+:8];
        if (w && a[7:6] == 2'h1 && !umode)
        begin
            path_m[2*int'(a[5:2])+:2] <= d[5:4];
            used_m[a[5:2]] <= d[6];
        end
        @(posedge ref_clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m);
        xfer(1'b0, a, 32'h0000_0000, 4'h0);
        chk("read", q & m, rd_exp(a) & m);
    endtask
    task automatic burst(input int n);
        run <= 1'b1;
        repeat (n) @(posedge ref_clk_in);
        run <= 1'b0;
        // a block caught mid source change ends it after up to ~16 cycles with its enable
        // following run, now low, then needs a source fall to drop its latch
        repeat (40) @(posedge ref_clk_in);
    endtask
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            prv = 16'h0000;
            lat = 16'h0000;
            eo = 16'h0000;
            lr = 4'h0;
            umode <= 1'b0;
            lcfg <= 32'h0000_0000;
            path_m <= 32'h0000_0000;
            used_m <= 16'hFFFF;
        end
        else
        begin
            for (int i = 0; i < 16; i++)
            begin
                s = src_of(i);
                if (prv[i] && !s)
                    lat[i] = en[i] && used_m[i];
                eo[i] = s && lat[i] && used_m[i];
                prv[i] = s;
            end
            for (int k = 0; k < 4; k++)
                lr[k] = src[4*k+int'(lcfg[4*k+1] ? sw[k] : lcfg[4*k])];
        end
    end
    always @(negedge ref_clk_in)
    begin
        chk("net", 32'(global_clock_out), 32'(eo));
        chk("loop ref", 32'(loop_ref_out), 32'(lr));
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk_in);
        bad_count++;
        $display("wrong value at %0t: run did not finish", $time);
        end_sim();
    end
    initial
    begin
        seed = $urandom(42);
        rst_n_in <= 1'b0;
        run <= 1'b0;
        avs_address_in <= 8'h00;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        avs_writedata_in <= 32'h0000_0000;
        avs_byteenable_in <= 4'h0;
        repeat (12) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        rd(8'h08, 32'hFFFF_FFFF);
        rd(8'h7C, 32'h0000_0070);
        xfer(1'b1, 8'h80, 32'hFFFF_FFFF, 4'hF);
        rd(8'h80, 32'hFFFF_FFFF);
        xfer(1'b1, 8'h04, $urandom, 4'hF);
        rd(8'h04, 32'h0000_FFFF);
        xfer(1'b1, 8'h04, 32'hFFFF_FF25, 4'h1);
        rd(8'h04, 32'h0000_FFFF);
        xfer(1'b1, 8'h44, 32'h0000_0060, 4'hF);
        xfer(1'b1, 8'h48, 32'h0000_0000, 4'hF);
        xfer(1'b1, 8'h54, 32'h0000_0070, 4'hF);
        xfer(1'b1, 8'h4C, 32'h0000_0050, 4'hF);
        xfer(1'b1, 8'h7C, 32'h0000_0050, 4'hF);
        rd(8'h44, 32'h0000_0070);
        burst(1500);
        rd(8'h08, 32'hFFFF_FFFF);
        xfer(1'b1, 8'h00, 32'h0000_0001, 4'hF);
        xfer(1'b1, 8'h04, 32'h0000_A5A5, 4'hF);
        xfer(1'b1, 8'h44, 32'h0000_0040, 4'hF);
        rd(8'h04, 32'h0000_FFFF);
        rd(8'h44, 32'h0000_0070);
        xfer(1'b1, 8'h00, 32'h0000_0000, 4'hF);
        rd(8'h08, 32'hFFFF_FFFF);
        burst(500);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        rd(8'h00, 32'hFFFF_FFFF);
        rd(8'h48, 32'h0000_0070);
        end_sim();
    end
endmodule
`default_nettype wire
